// file: design/dac_gc_pkg.sv
package dac_gc_pkg;
  localparam logic [7:0] GC_ADDR_BYTE = 8'h00;
  localparam logic [7:0] CMD_WAKE = 8'h0A;
  localparam logic [7:0] CMD_RESET = 8'h06;
  localparam logic [1:0] PD_ACTIVE = 2'h0;
  localparam logic [1:0] REF_SUPPLY = 2'h0;
  localparam logic [2:0] LAST_BIT = 3'h7;
  localparam int RW_BIT = 0;
  localparam int ADDR_MSB = 7;
  localparam int ADDR_LSB = 1;
  localparam int CLK_PERIOD_NS = 40;
  localparam int DEF_CHANNELS = 2;
  localparam int DEF_RES = 12;
  localparam logic [6:0] DEF_DEV_ADDR = 7'h60;

  typedef enum logic [2:0] {
    S_IDLE,
    S_ADDR,
    S_ACK,
    S_GCCMD,
    S_IGNORE
  } phase_t;
endpackage : dac_gc_pkg

// file: design/line_events_if.sv
`timescale 1ns/1ps
interface line_events_if;
  logic start;
  logic stop;
  logic rise;
  logic fall;
  logic sdaNow;
  modport mon (output start, stop, rise, fall, sdaNow);
  modport core (input start, stop, rise, fall, sdaNow);
endinterface : line_events_if

// file: design/line_monitor.sv
`timescale 1ns/1ps
module line_monitor (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic scl,
  input wire logic sdaIn,
  line_events_if.mon ev
);
  typedef struct packed {
    logic sclA;
    logic sdaA;
    logic sclB;
    logic sdaB;
  } mon_state_t;

  mon_state_t st_reg;
  mon_state_t st_next;

  always_comb begin
    st_next = st_reg;
    if (ce) begin
      st_next.sclA = scl;
      st_next.sdaA = sdaIn;
      st_next.sclB = st_reg.sclA;
      st_next.sdaB = st_reg.sdaA;
    end
  end

  // Idle-high reset value keeps a spurious SCL rise from firing after reset
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_reg <= '{sclA: 1'b1, sdaA: 1'b1, sclB: 1'b1, sdaB: 1'b1};
    end else begin
      st_reg <= st_next;
    end
  end

  assign ev.start = st_reg.sclA & st_reg.sclB & st_reg.sdaB & ~st_reg.sdaA;
  assign ev.stop = st_reg.sclA & st_reg.sclB & ~st_reg.sdaB & st_reg.sdaA;
  assign ev.rise = st_reg.sclA & ~st_reg.sclB;
  assign ev.fall = ~st_reg.sclA & st_reg.sclB;
  assign ev.sdaNow = st_reg.sdaA;
endmodule : line_monitor

// file: design/dac_gc_slave.sv
`timescale 1ns/1ps
// Overview of operation
// - Acknowledge all-zero first byte; next byte is the general call command.
// - Command byte 00001010 clears all volatile power-down selections to 00.
// - Power-down clearing happens at SCL rise of the command's last data bit.
// - Drive acknowledge low after general call address and after wake-up byte.
// - No Stop needed after wake-up; further wake-up or reset codes accepted.
// - Own address with read bit high is acknowledged with 0; master then stops.
// - Reference selection 00 makes the supply rail that channel's reference.
// - Per-channel gain selection bit chooses output amplifier gain of 1 or 2.
// - Output is code times gain over two to the resolution; 4096 steps.
module dac_gc_slave
  import dac_gc_pkg::*;
#(
  parameter int CH = DEF_CHANNELS,
  parameter int RES = DEF_RES,
  parameter logic [6:0] DEV_ADDR = DEF_DEV_ADDR
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic scl,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  input wire logic cfgLoad,
  input wire logic [CH-1:0][1:0] cfgPowerDown,
  input wire logic [CH-1:0][1:0] cfgRef,
  input wire logic [CH-1:0] cfgGain,
  input wire logic dacLoad,
  input wire logic [CH-1:0][RES-1:0] dacCode,
  output logic [CH-1:0][1:0] powerDownSel,
  output logic [CH-1:0][1:0] referenceSelect,
  output logic [CH-1:0] gainSelect,
  output logic [CH-1:0] supplyRefOn,
  output logic [CH-1:0][RES:0] scaledCode,
  output logic wakeEvent
);
  typedef struct packed {
    phase_t phase;
    phase_t after;
    logic [2:0] bitCnt;
    logic [7:0] shift;
    logic ackPending;
    logic ackArmed;
    logic drive;
    logic sdaLevel;
    logic wake;
    logic [CH-1:0][1:0] pd;
    logic [CH-1:0][1:0] refPick;
    logic [CH-1:0] gain;
    logic [CH-1:0] supply;
    logic [CH-1:0][RES-1:0] code;
    logic [CH-1:0][RES:0] scaled;
  } core_state_t;

  core_state_t st_reg;
  core_state_t st_next;
  logic [7:0] byteNow;

  line_events_if ev ();

  line_monitor u_mon (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .scl(scl),
    .sdaIn(sdaIn),
    .ev(ev)
  );

  function automatic logic [7:0] nextByte(input logic [7:0] sh,
                                          input logic b);
    nextByte = {sh[6:0], b};
  endfunction : nextByte

  // Gain 2 is a one-bit left shift of the code
  function automatic logic [RES:0] scale(input logic [RES-1:0] c,
                                         input logic g);
    scale = g ? {c, 1'b0} : {1'b0, c};
  endfunction : scale

  assign byteNow = nextByte(st_reg.shift, ev.sdaNow);

  always_comb begin
    st_next = st_reg;
    if (ce) begin
      st_next.wake = 1'b0;
      if (cfgLoad) begin
        st_next.pd = cfgPowerDown;
        st_next.refPick = cfgRef;
        st_next.gain = cfgGain;
      end
      if (dacLoad) begin
        st_next.code = dacCode;
      end
      if (ev.start) begin
        st_next.phase = S_ADDR;
        st_next.bitCnt = '0;
        st_next.drive = 1'b0;
        st_next.ackArmed = 1'b0;
      end else if (ev.stop) begin
        st_next.phase = S_IDLE;
        st_next.drive = 1'b0;
        st_next.ackArmed = 1'b0;
      end else begin
        unique case (st_reg.phase)
          S_IDLE, S_IGNORE: begin
            st_next.drive = 1'b0;
          end
          S_ADDR, S_GCCMD: begin
            if (ev.rise) begin
              st_next.shift = byteNow;
              st_next.bitCnt = st_reg.bitCnt + 3'h1;
              if (st_reg.bitCnt == LAST_BIT) begin
                st_next.phase = S_ACK;
                st_next.ackPending = 1'b0;
                st_next.after = S_IGNORE;
                if (st_reg.phase == S_ADDR) begin
                  if (byteNow == GC_ADDR_BYTE) begin
                    st_next.ackPending = 1'b1;
                    st_next.after = S_GCCMD;
                  end else if (byteNow[ADDR_MSB:ADDR_LSB] == DEV_ADDR) begin
                    // Only probing is served; data bytes are not decoded
                    st_next.ackPending = 1'b1;
                  end
                end else if (byteNow == CMD_WAKE) begin
                  st_next.pd = '0;
                  st_next.wake = 1'b1;
                  st_next.ackPending = 1'b1;
                  st_next.after = S_GCCMD;
                end else if (byteNow == CMD_RESET) begin
                  // Reset action itself belongs to a neighbouring block
                  st_next.ackPending = 1'b1;
                  st_next.after = S_GCCMD;
                end
              end
            end
          end
          S_ACK: begin
            if (ev.fall) begin
              if (!st_reg.ackArmed) begin
                st_next.ackArmed = 1'b1;
                st_next.drive = st_reg.ackPending;
              end else begin
                st_next.ackArmed = 1'b0;
                st_next.drive = 1'b0;
                st_next.phase = st_reg.after;
                st_next.bitCnt = '0;
              end
            end
          end
          default: begin
            st_next.phase = S_IDLE;
            st_next.drive = 1'b0;
          end
        endcase
      end
      for (int i = 0; i < CH; i++) begin
        st_next.supply[i] = (st_next.refPick[i] == REF_SUPPLY);
        st_next.scaled[i] = scale(st_next.code[i], st_next.gain[i]);
      end
    end
  end

  // Reset leaves channels powered with supply reference and unity gain
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_reg <= '{phase: S_IDLE, after: S_IDLE, refPick: {CH{REF_SUPPLY}},
                  pd: {CH{PD_ACTIVE}}, supply: '1, default: '0};
    end else begin
      st_reg <= st_next;
    end
  end

  assign sdaOut = st_reg.sdaLevel;
  assign sdaOe = st_reg.drive;
  assign powerDownSel = st_reg.pd;
  assign referenceSelect = st_reg.refPick;
  assign gainSelect = st_reg.gain;
  assign supplyRefOn = st_reg.supply;
  assign scaledCode = st_reg.scaled;
  assign wakeEvent = st_reg.wake;

  logic wakeHit;
  logic byteEnd;
  assign byteEnd = ce && !ev.start && !ev.stop && ev.rise &&
                   st_reg.bitCnt == LAST_BIT;
  assign wakeHit = byteEnd && st_reg.phase == S_GCCMD &&
                   byteNow == CMD_WAKE;

  a_gc_addr_ack: assert property (@(posedge clk) disable iff (rst)
    byteEnd && st_reg.phase == S_ADDR && byteNow == GC_ADDR_BYTE |=>
    st_reg.phase == S_ACK && st_reg.ackPending && st_reg.after == S_GCCMD)
    else $error("general call address not acknowledged");

  a_wake_clears_pd: assert property (@(posedge clk) disable iff (rst)
    wakeHit |=> powerDownSel == '0 && wakeEvent)
    else $error("wake-up did not clear power-down");

  a_wake_timing: assert property (@(posedge clk) disable iff (rst)
    $rose(wakeEvent) |-> $past(ev.rise) && $past(st_reg.bitCnt) == LAST_BIT)
    else $error("wake-up not at last data bit rise");

  a_ack_drive_low: assert property (@(posedge clk) disable iff (rst)
    st_reg.phase == S_ACK && st_reg.ackArmed && st_reg.ackPending
    |-> sdaOe && !sdaOut)
    else $error("acknowledge not driven low");

  a_cmd_chain: assert property (@(posedge clk) disable iff (rst)
    ce && !ev.start && !ev.stop && ev.fall && st_reg.phase == S_ACK &&
    st_reg.ackArmed && st_reg.after == S_GCCMD
    |=> st_reg.phase == S_GCCMD && st_reg.bitCnt == 3'h0 && !sdaOe)
    else $error("command phase not re-entered after ack");

  a_probe_ack: assert property (@(posedge clk) disable iff (rst)
    byteEnd && st_reg.phase == S_ADDR && byteNow[RW_BIT] &&
    byteNow[ADDR_MSB:ADDR_LSB] == DEV_ADDR
    |=> st_reg.ackPending && st_reg.after == S_IGNORE)
    else $error("probe address not acknowledged");

  a_supply_ref: assert property (@(posedge clk) disable iff (rst)
    ##1 supplyRefOn[0] == (referenceSelect[0] == REF_SUPPLY))
    else $error("supply reference flag wrong");

  a_gain_follow: assert property (@(posedge clk) disable iff (rst)
    ce && cfgLoad && !wakeHit |=> gainSelect == $past(cfgGain))
    else $error("gain selection not loaded");

  a_scale_ch0: assert property (@(posedge clk) disable iff (rst)
    ##1 int'(scaledCode[0]) ==
    int'(st_reg.code[0]) * (gainSelect[0] ? 2 : 1))
    else $error("scaled code mismatch");

  a_wake_keeps_code: assert property (@(posedge clk) disable iff (rst)
    wakeHit && !dacLoad && !cfgLoad
    |=> $stable(st_reg.code) && $stable(referenceSelect) &&
    $stable(gainSelect))
    else $error("wake-up changed other settings");

  c_wake: cover property (@(posedge clk) disable iff (rst) wakeEvent);
  c_double_wake: cover property (@(posedge clk) disable iff (rst)
    wakeEvent ##[1:400] wakeEvent);
  c_probe: cover property (@(posedge clk) disable iff (rst)
    st_reg.phase == S_ACK && st_reg.after == S_IGNORE && sdaOe);
  c_nack: cover property (@(posedge clk) disable iff (rst)
    st_reg.phase == S_ACK && st_reg.ackArmed && !st_reg.ackPending);
endmodule : dac_gc_slave

// file: test/i2c_master_model.sv
`timescale 1ns/1ps
module i2c_master_model (
  input wire logic clk,
  input wire logic sdaWire,
  output logic scl,
  output logic sdaLow
);
  // Idle bus: both lines released, pull-ups hold them high
  initial begin
    scl = 1'h1;
    sdaLow = 1'h0;
  end

  // Each line level held 4 clocks, above the 3-clock minimum
  task automatic hold();
    repeat (4) @(posedge clk);
  endtask : hold

  // Also serves as a repeated start, so no stop is needed between codes
  task automatic startCond();
    sdaLow <= 1'h0;
    hold();
    scl <= 1'h1;
    hold();
    sdaLow <= 1'h1;
    hold();
    scl <= 1'h0;
    hold();
  endtask : startCond

  task automatic stopCond();
    sdaLow <= 1'h1;
    hold();
    scl <= 1'h1;
    hold();
    sdaLow <= 1'h0;
    hold();
  endtask : stopCond

  // Data changes only while SCL is low; the line is sampled late in the high
  task automatic xferBit(input logic b, output logic r);
    sdaLow <= !b;
    hold();
    scl <= 1'h1;
    hold();
    r = sdaWire;
    scl <= 1'h0;
    hold();
  endtask : xferBit
endmodule : i2c_master_model

// file: test/tb.sv
`timescale 1ns/1ps
module tb;
  import dac_gc_pkg::*;
  `define CHK(a, b, m) begin \
    totalChecks++; \
    if ((a) !== (b)) begin \
      failCount++; \
      $display("mismatch at %0t: %s", $time, m); \
    end \
  end
  logic clk, rst, ce, sdaOut, sdaOe, cfgLoad, dacLoad, wakeEvent;
  logic sclLine, masterLow;
  logic [DEF_CHANNELS-1:0][1:0] cfgPd, cfgRf, pdSel, refSel, expPd;
  logic [DEF_CHANNELS-1:0] cfgGn, gainSel, supplyOn;
  logic [DEF_CHANNELS-1:0][DEF_RES-1:0] code;
  logic [DEF_CHANNELS-1:0][DEF_RES:0] scaled;
  int failCount, totalChecks, wakeCount, expWakes, cycles, seed;
  // Open-drain wire: low if either party pulls, else pulled up
  wire sdaWire = !(masterLow || (sdaOe && !sdaOut));

  dac_gc_slave #(.CH(DEF_CHANNELS), .RES(DEF_RES), .DEV_ADDR(DEF_DEV_ADDR))
  dac_gc_slave_inst (.clk(clk), .rst(rst), .ce(ce), .scl(sclLine),
    .sdaIn(sdaWire), .sdaOut(sdaOut), .sdaOe(sdaOe), .cfgLoad(cfgLoad),
    .cfgPowerDown(cfgPd), .cfgRef(cfgRf), .cfgGain(cfgGn), .dacLoad(dacLoad),
    .dacCode(code), .powerDownSel(pdSel), .referenceSelect(refSel),
    .gainSelect(gainSel), .supplyRefOn(supplyOn), .scaledCode(scaled),
    .wakeEvent(wakeEvent));
  i2c_master_model i2c_master_model_inst (.clk(clk), .sdaWire(sdaWire),
    .scl(sclLine), .sdaLow(masterLow));

  initial begin
    clk = 1'h0;
    forever #(CLK_PERIOD_NS / 2) clk = ~clk;
  end

  always @(negedge clk) begin
    if (wakeEvent === 1'h1) wakeCount++;
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      failCount++;
      giveVerdict();
    end
  end

  function automatic logic [DEF_RES:0] expScaled(logic [DEF_RES-1:0] c,
                                                 logic g);
    return g ? {c, 1'h0} : {1'h0, c};
  endfunction : expScaled

  task automatic giveVerdict();
    if (failCount == 0 && totalChecks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : giveVerdict

  task automatic checkAll();
    for (int c = 0; c < DEF_CHANNELS; c++) begin
      `CHK(pdSel[c], expPd[c], "power down select")
      `CHK(refSel[c], cfgRf[c], "reference select")
      `CHK(supplyOn[c], cfgRf[c] == REF_SUPPLY, "supply ref")
      `CHK(gainSel[c], cfgGn[c], "gain select")
      `CHK(scaled[c], expScaled(code[c], cfgGn[c]), "scaled code")
    end
  endtask : checkAll

  task automatic load(input logic [3:0] p, input logic [3:0] r,
                      input logic [1:0] g, input logic [23:0] d);
    @(posedge clk);
    cfgPd <= p;
    cfgRf <= r;
    cfgGn <= g;
    code <= d;
    cfgLoad <= 1'h1;
    dacLoad <= 1'h1;
    @(posedge clk);
    cfgLoad <= 1'h0;
    dacLoad <= 1'h0;
    expPd = p;
    @(negedge clk);
    checkAll();
  endtask : load

  // Clock enable low must freeze the power-down selection, a pending load included
  task automatic freezeCheck();
    @(posedge clk);
    ce <= 1'h0;
    cfgLoad <= 1'h1;
    cfgPd <= ~expPd;
    repeat (4) @(posedge clk);
    `CHK(pdSel, expPd, "load taken while clock enable low")
    ce <= 1'h1;
    cfgLoad <= 1'h0;
    cfgPd <= expPd;
    @(negedge clk);
    checkAll();
  endtask : freezeCheck

  // Power-down must already be clear before the acknowledge clock
  task automatic sendByte(input logic [7:0] b, input logic ack,
                          input logic wake);
    logic r;
    for (int i = 7; i >= 0; i--) i2c_master_model_inst.xferBit(b[i], r);
    if (wake) begin
      expPd = '0;
      expWakes++;
    end
    checkAll();
    i2c_master_model_inst.xferBit(1'h1, r);
    `CHK(r, !ack, "acknowledge")
    `CHK(wakeCount, expWakes, "wake pulse count")
  endtask : sendByte

  initial begin
    seed = 69;
    rst = 1'h1;
    ce = 1'h1;
    {cfgLoad, dacLoad, cfgPd, cfgRf, cfgGn, code, expPd} = '0;
    repeat (20) @(posedge clk);
    rst <= 1'h0;
    repeat (3) @(posedge clk);
    checkAll();
    load(4'h0, 4'h0, 2'h3, 24'hFF_FFFF);
    for (int n = 0; n < 8; n++) begin
      load(4'($random(seed)), 4'($random(seed)), 2'($random(seed)),
           24'($random(seed)));
    end
    freezeCheck();
    load(4'hF, 4'h6, 2'h1, 24'h12_3456);
    i2c_master_model_inst.startCond();
    sendByte(GC_ADDR_BYTE, 1'h1, 1'h0);
    sendByte(CMD_WAKE, 1'h1, 1'h1);
    load(4'h9, 4'h1, 2'h2, 24'hAB_C0FF);
    sendByte(CMD_WAKE, 1'h1, 1'h1);
    sendByte(CMD_RESET, 1'h1, 1'h0);
    i2c_master_model_inst.stopCond();
    // Unsupported codes are refused and what follows is ignored
    load(4'h5, 4'h2, 2'h0, 24'h0F_FF00);
    i2c_master_model_inst.startCond();
    sendByte(GC_ADDR_BYTE, 1'h1, 1'h0);
    sendByte(8'h04, 1'h0, 1'h0);
    sendByte(CMD_WAKE, 1'h0, 1'h0);
    i2c_master_model_inst.startCond();
    sendByte(GC_ADDR_BYTE, 1'h1, 1'h0);
    sendByte(8'h00, 1'h0, 1'h0);
    i2c_master_model_inst.startCond();
    sendByte(GC_ADDR_BYTE, 1'h1, 1'h0);
    sendByte(CMD_WAKE, 1'h1, 1'h1);
    i2c_master_model_inst.stopCond();
    load(4'hA, 4'h0, 2'h1, 24'h55_5AAA);
    i2c_master_model_inst.startCond();
    sendByte({DEF_DEV_ADDR, 1'h1}, 1'h1, 1'h0);
    i2c_master_model_inst.stopCond();
    i2c_master_model_inst.startCond();
    sendByte({DEF_DEV_ADDR ^ 7'h01, 1'h1}, 1'h0, 1'h0);
    i2c_master_model_inst.stopCond();
    giveVerdict();
  end
endmodule : tb
